/* File: common/interval_timer_pkg.sv */
// Constants, register offsets and field layout for the 16-bit interval timer.
// Assumes a simple strobe register port and a single core clock.
//
// Functional notes
// - Writing one to the run bit starts the 16-bit timer and writing zero stops it.
// - With the idle-halt bit set the timer stops in Idle mode, otherwise it keeps running.
// - The gated-accumulation bit enables gating only when the internal clock is selected.
// - The prescale code selects 1:1, 1:8, 1:64 or 1:256 for codes 00, 01, 10 and 11.
// - With the external clock selected the sync bit chooses synchronized or raw edges; here both pass the synchronizer, raw ones one cycle earlier.
// - The clock-source bit picks external rising edges (one) or the Fosc/2 internal clock.
// - Control bits 14, 12 to 7, 3 and 0 always read as zero.
// - Any control write while running resets the prescale counter.
// - The interrupt is raised on period match or, in gated mode, on the gate falling edge.
// - The counter is 16 bits wide and works as timer, synchronous or asynchronous counter; the asynchronous one still runs on core_clk.
// - The timer keeps working in Idle or Sleep, subject to the idle-halt setting.
package interval_timer_pkg;

    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_COUNT     = 4'h1;
    localparam logic [3:0] ADDR_PERIOD    = 4'h2;
    localparam logic [3:0] ADDR_IRQ       = 4'h3;

    // ----------------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------------
    localparam int BIT_RUN        = 15;
    localparam int BIT_IDLE_HALT  = 13;
    localparam int BIT_GATED      = 6;
    localparam int BIT_PS_HI      = 5;
    localparam int BIT_PS_LO      = 4;
    localparam int BIT_SYNC       = 2;
    localparam int BIT_SOURCE     = 1;
    localparam logic [15:0] CONTROL_MASK  = 16'ha076;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET  = 16'hffff;

    // Interrupt register: bit 0 flag, bit 1 enable, bits 4..2 priority.
    localparam int BIT_IRQ_FLAG   = 0;
    localparam int BIT_IRQ_EN     = 1;
    localparam int BIT_PRIO_LO    = 2;
    localparam int BIT_PRIO_HI    = 4;

    // ----------------------------------------------------------------------
    // Prescale ratios
    // ----------------------------------------------------------------------
    localparam logic [1:0] PS_DIV1   = 2'h0;
    localparam logic [1:0] PS_DIV8   = 2'h1;
    localparam logic [1:0] PS_DIV64  = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam logic [7:0] PS_LAST8   = 8'h07;
    localparam logic [7:0] PS_LAST64  = 8'h3f;
    localparam logic [7:0] PS_LAST256 = 8'hff;

    // Terminal prescale count for a code.
    function automatic logic [7:0] ps_last(input logic [1:0] code);
        unique case (code)
            PS_DIV1:   ps_last = 8'h00;
            PS_DIV8:   ps_last = PS_LAST8;
            PS_DIV64:  ps_last = PS_LAST64;
            PS_DIV256: ps_last = PS_LAST256;
        endcase
    endfunction : ps_last

endpackage : interval_timer_pkg

/* File: hdl/edge_sync.sv */
// Two-stage synchronizer with a rising and falling edge detector after it.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/10ps
module edge_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Pin side
    input  wire logic pinIn,
    // Core side
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_stage1;
    logic next_stage2;
    logic next_stage3;

    // -----------------------------------------------------------------------
    // Synchronizer
    // -----------------------------------------------------------------------
    // Only stage2 reads stage1 so metastability cannot spread.
    always_comb begin
        next_stage1 = pinIn;
        next_stage2 = stage1;
        next_stage3 = stage2;
    end

    // Registered copies of the pin.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
        end
    end

    // Edges are one cycle long pulses.
    assign level = stage2;
    assign rise  = stage2 & ~stage3;
    assign fall  = ~stage2 & stage3;

endmodule : edge_sync

/* File: hdl/interval_timer.sv */
// Top of the 16-bit interval timer with its register port.
// Assumes one 100 MHz core clock; external clock and gate pins are asynchronous.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module interval_timer
    import interval_timer_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Register port
    input  wire logic [3:0]       regAddr,
    input  wire logic [15:0]      regWdata,
    input  wire logic             regWrite,
    input  wire logic             regRead,
    output logic      [15:0]      regRdata,
    // Power state
    input  wire logic             idleMode,
    // Pins
    input  wire logic             timerExtClockPin,
    input  wire logic             gatePin,
    // Interrupt request
    output logic                  timerIrq,
    output logic      [2:0]       timerIrqPriority
);

    logic [15:0]      timerControl;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] periodValue;
    logic [7:0]       prescale;
    logic             irqFlag;
    logic             timerIrqEnable;
    logic [2:0]       prio;
    logic             rawDelay;
    logic             halfPhase;
    logic [15:0]      next_timerControl;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] next_periodValue;
    logic [7:0]       next_prescale;
    logic             next_irqFlag;
    logic             next_timerIrqEnable;
    logic [2:0]       next_prio;
    logic             next_rawDelay;
    logic             next_halfPhase;
    logic [15:0]      next_regRdata;

    logic extLevel;
    logic extRise;
    logic gateLevel;
    logic gateFall;
    logic timerRun;
    logic idleHalt;
    logic gatedAccumulate;
    logic extClockSync;
    logic clockSourceSelect;
    logic [1:0] prescaleSelect;
    logic active;
    logic srcTick;
    logic tick;
    logic matchEvent;
    logic gateEvent;
    logic ctrlWrite;

    // -----------------------------------------------------------------------
    // Pin conditioning
    // -----------------------------------------------------------------------
    edge_sync u_ext_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pinIn    (timerExtClockPin),
        .level    (extLevel),
        .rise     (extRise),
        .fall     ()
    );

    edge_sync u_gate_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pinIn    (gatePin),
        .level    (gateLevel),
        .rise     (),
        .fall     (gateFall)
    );

    // -----------------------------------------------------------------------
    // Control decode
    // -----------------------------------------------------------------------
    assign timerRun          = timerControl[BIT_RUN];
    assign idleHalt          = timerControl[BIT_IDLE_HALT];
    assign gatedAccumulate   = timerControl[BIT_GATED];
    assign prescaleSelect    = timerControl[BIT_PS_HI:BIT_PS_LO];
    assign extClockSync      = timerControl[BIT_SYNC];
    assign clockSourceSelect = timerControl[BIT_SOURCE];
    assign ctrlWrite         = regWrite && (regAddr == ADDR_CONTROL);

    // Runs when on, and in Idle only when idle-halt is clear; Sleep is not gated here.
    assign active = timerRun && !(idleMode && idleHalt);

    // -----------------------------------------------------------------------
    // Tick source
    // -----------------------------------------------------------------------
    // Both external paths pass the synchronizer; the unsynchronized path only
    // skips the one-cycle edge-alignment stage, so it is one cycle earlier.
    // A truly asynchronous counter would need a second clock domain.
    always_comb begin
        next_halfPhase = ~halfPhase;
        next_rawDelay  = extRise;
        if (clockSourceSelect) begin
            srcTick = extClockSync ? rawDelay : extRise;
        end else if (gatedAccumulate) begin
            srcTick = halfPhase && gateLevel;
        end else begin
            srcTick = halfPhase;
        end
    end

    // Prescaler; tick fires when it reaches the terminal count for the code.
    assign tick = active && srcTick && (prescale == ps_last(prescaleSelect));

    assign matchEvent = tick && (count == periodValue);
    assign gateEvent  = active && !clockSourceSelect && gatedAccumulate && gateFall;

    // -----------------------------------------------------------------------
    // Counter, prescaler and registers
    // -----------------------------------------------------------------------
    always_comb begin
        next_timerControl   = timerControl;
        next_periodValue    = periodValue;
        next_timerIrqEnable = timerIrqEnable;
        next_prio           = prio;
        next_count          = count;
        next_prescale       = prescale;
        next_irqFlag        = irqFlag;
        if (active && srcTick) begin
            next_prescale = tick ? 8'h00 : prescale + 8'h01;
        end
        if (tick) begin
            next_count = matchEvent ? '0 : count + 1'b1;
        end
        if (regWrite) begin
            unique case (regAddr)
                ADDR_CONTROL: begin
                    next_timerControl = regWdata & CONTROL_MASK;
                end
                ADDR_COUNT:   next_count = regWdata[WIDTH-1:0];
                ADDR_PERIOD:  next_periodValue = regWdata[WIDTH-1:0];
                ADDR_IRQ: begin
                    next_irqFlag        = regWdata[BIT_IRQ_FLAG];
                    next_timerIrqEnable = regWdata[BIT_IRQ_EN];
                    next_prio           = regWdata[BIT_PRIO_HI:BIT_PRIO_LO];
                end
                default: ;
            endcase
        end
        // A control write always restarts the prescale count.
        if (ctrlWrite) begin
            next_prescale = 8'h00;
        end
        // A new event wins over a software clear in the same cycle.
        if (matchEvent || gateEvent) begin
            next_irqFlag = 1'b1;
        end
    end

    // Read data for the cycle after the strobe.
    always_comb begin
        next_regRdata = 16'h0000;
        if (regRead) begin
            unique case (regAddr)
                ADDR_CONTROL: next_regRdata = timerControl & CONTROL_MASK;
                ADDR_COUNT:   next_regRdata = 16'(count);
                ADDR_PERIOD:  next_regRdata = 16'(periodValue);
                ADDR_IRQ:     next_regRdata = {11'h000, prio, timerIrqEnable, irqFlag};
                default:      next_regRdata = 16'h0000;
            endcase
        end
    end

    // State registers.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timerControl   <= CONTROL_RESET;
            periodValue    <= WIDTH'(PERIOD_RESET);
            timerIrqEnable <= 1'b0;
            prio           <= 3'h0;
            count          <= '0;
            prescale       <= 8'h00;
            irqFlag        <= 1'b0;
            rawDelay       <= 1'b0;
            halfPhase      <= 1'b0;
            regRdata       <= 16'h0000;
        end else begin
            timerControl   <= next_timerControl;
            periodValue    <= next_periodValue;
            timerIrqEnable <= next_timerIrqEnable;
            prio           <= next_prio;
            count          <= next_count;
            prescale       <= next_prescale;
            irqFlag        <= next_irqFlag;
            rawDelay       <= next_rawDelay;
            halfPhase      <= next_halfPhase;
            regRdata       <= next_regRdata;
        end
    end

    assign timerIrq         = irqFlag && timerIrqEnable;
    assign timerIrqPriority = prio;

    // -----------------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------------
    sequence s_match_tick;
        tick && (count == periodValue);
    endsequence

    a_match_wraps: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_match_tick and !regWrite) |=> (count == '0) && irqFlag)
        else $error("Count did not wrap and flag at period match.");

    a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        (matchEvent || gateEvent) |=> irqFlag)
        else $error("Interrupt flag lost on event.");

    a_stopped_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        !timerRun && !regWrite |=> $stable(count))
        else $error("Count moved while stopped.");

    a_idle_halts: assert property (@(posedge core_clk) disable iff (!rst_n)
        idleMode && idleHalt && !regWrite |=> $stable(count))
        else $error("Count moved in Idle with halt set.");

    a_ctrl_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
        regRead && regAddr == ADDR_CONTROL |=> (regRdata & ~CONTROL_MASK) == 16'h0000)
        else $error("Unimplemented control bits read nonzero.");

    a_ctrl_resets_ps: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrlWrite |=> prescale == 8'h00)
        else $error("Prescaler not cleared by control write.");

    a_gate_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        !clockSourceSelect && gatedAccumulate && !gateLevel |-> !tick)
        else $error("Tick while gate low.");

    a_div1_rate: assert property (@(posedge core_clk) disable iff (!rst_n)
        active && !clockSourceSelect && !gatedAccumulate && prescaleSelect == PS_DIV1
        && !regWrite ##1 active && !regWrite |-> tick || $past(tick))
        else $error("Internal 1:1 clock not at half rate.");

endmodule : interval_timer

/* File: verification/pin_source.sv */
// Behavioural source for the external count clock and the gate pin.
// Assumes the bench calls its tasks; it keeps its own time base.
`timescale 1ns/10ps
module pin_source (
    // Pins
    output logic extClock,
    output logic gate
);
    // ------------------------------------------------------------------
    // Pin stimulus
    // ------------------------------------------------------------------
    // The clock rests low between bursts, as a source that is switched off would.
    initial begin
        extClock = 1'b0;
        gate     = 1'b0;
    end

    // A 27 ns half period keeps edges out of phase with the core clock.
    // Each level lasts over two core cycles, so no edge is lost in the synchronizer.
    task automatic pulses(input int n);
        repeat (n) begin
            #27 extClock = 1'b1;
            #27 extClock = 1'b0;
        end
        #27;
    endtask : pulses

    // The gate changes off the core clock edges, like any asynchronous input.
    task automatic setGate(input logic v);
        #13 gate = v;
    endtask : setGate
endmodule : pin_source

/* File: verification/interval_timer_tb.sv */
// Self-checking bench for the interval timer through its register port.
// Assumes the strobe port of the design and the pin source model beside it.
`timescale 1ns/10ps
module interval_timer_tb;
    import interval_timer_pkg::*;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    logic        core_clk;
    logic        rst_n;
    logic [3:0]  regAddr;
    logic [15:0] regWdata;
    logic        regWrite;
    logic        regRead;
    logic [15:0] regRdata;
    logic        idleMode;
    logic        extClock;
    logic        gate;
    logic        timerIrq;
    logic [2:0]  timerIrqPriority;
    logic [15:0] v;
    int          failures;
    int          checks;

    interval_timer dut_u (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .idleMode(idleMode), .timerExtClockPin(extClock), .gatePin(gate),
        .timerIrq(timerIrq), .timerIrqPriority(timerIrqPriority));
    pin_source src_u (.extClock(extClock), .gate(gate));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // A count within a window; an unknown count never lands inside it.
    task automatic chkRange(input string name, input logic [15:0] seen,
                            input logic [15:0] lo, input logic [15:0] hi);
        check(name, {15'h0000, (seen >= lo) && (seen <= hi)}, 16'h0001);
    endtask : chkRange

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    // Clear, start, restart while running to zero the prescaler, wait, stop, read.
    task automatic measure(input logic [15:0] ctrl, input int cyc, output logic [15:0] c);
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_CONTROL, ctrl);
        wr(ADDR_CONTROL, ctrl);
        idle(cyc);
        wr(ADDR_CONTROL, ctrl & 16'h7fff);
        rd(ADDR_COUNT, c);
    endtask : measure

    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // The run takes about 15k cycles; the limit of 50k cycles leaves ample room.
    initial begin
        #500000;
        failures++;
        results();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        failures = 0;
        checks   = 0;
        rst_n    = 1'b0;
        regAddr  = 4'h0;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead  = 1'b0;
        idleMode = 1'b0;
        idle(4);
        rst_n <= 1'b1;
        // Reset values, and an unmapped index that ignores writes.
        rd(ADDR_CONTROL, v);
        check("control reset", v, CONTROL_RESET);
        rd(ADDR_PERIOD, v);
        check("period reset", v, PERIOD_RESET);
        wr(4'h9, 16'h5a5a);
        rd(4'h9, v);
        check("unmapped", v, 16'h0000);
        // Unimplemented control bits read as zero.
        wr(ADDR_CONTROL, 16'h7fff);
        rd(ADDR_CONTROL, v);
        check("control mask", v, 16'h2076);
        // Every prescale code over 20 expected ticks; 1:256 is four times 1:64.
        for (int k = 0; k < 4; k++) begin
            measure({10'h200, k[1:0], 4'h0}, (k == 3) ? 10240 : (40 << (3 * k)), v);
            chkRange("prescale count", v, 16'h0013, 16'h0017);
        end
        idle(20);
        rd(ADDR_COUNT, v);
        chkRange("stopped count", v, 16'h0013, 16'h0017);
        // A write while running restarts the 1:256 prescaler, so no tick arrives.
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_CONTROL, 16'h8030);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_CONTROL, 16'h8030);
            idle(400);
        end
        rd(ADDR_COUNT, v);
        check("prescale restart", v, 16'h0000);
        wr(ADDR_CONTROL, 16'h0000);
        // Idle halts the timer only when the idle-halt bit is set.
        idleMode <= 1'b1;
        measure(16'ha000, 40, v);
        check("idle halt", v, 16'h0000);
        measure(16'h8000, 40, v);
        chkRange("idle run", v, 16'h0013, 16'h0017);
        idleMode <= 1'b0;
        // Sixteen-bit wrap at the period value.
        wr(ADDR_COUNT, 16'hfffe);
        wr(ADDR_CONTROL, 16'h8000);
        idle(10);
        wr(ADDR_CONTROL, 16'h0000);
        rd(ADDR_COUNT, v);
        chkRange("wrap", v, 16'h0000, 16'h0006);
        // Period match raises the flag; enable gates the request and the priority is passed out beside it.
        wr(ADDR_IRQ, 16'h0016);
        wr(ADDR_PERIOD, 16'h0003);
        measure(16'h8000, 40, v);
        chkRange("match count", v, 16'h0000, 16'h0003);
        rd(ADDR_IRQ, v);
        check("match flag", v, 16'h0017);
        check("irq on", {15'h0000, timerIrq}, 16'h0001);
        check("priority", {13'h0000, timerIrqPriority}, 16'h0005);
        // The request follows the registers, so look once the write edge has settled.
        wr(ADDR_IRQ, 16'h0001);
        #1;
        check("irq masked", {15'h0000, timerIrq}, 16'h0000);
        wr(ADDR_IRQ, 16'h0002);
        #1;
        check("irq cleared", {15'h0000, timerIrq}, 16'h0000);
        wr(ADDR_PERIOD, 16'hffff);
        // External clock, synchronized and then not, ignores the internal clock.
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_CONTROL, 16'h8006);
        src_u.pulses(10);
        rd(ADDR_COUNT, v);
        check("ext sync", v, 16'h000a);
        wr(ADDR_CONTROL, 16'h8002);
        src_u.pulses(10);
        idle(100);
        rd(ADDR_COUNT, v);
        check("ext raw", v, 16'h0014);
        // Gate bit is ignored with the external clock.
        wr(ADDR_CONTROL, 16'h8046);
        src_u.pulses(5);
        rd(ADDR_COUNT, v);
        check("gate ignored", v, 16'h0019);
        // Gated accumulation: nothing while low, ticks while high, flag on the fall.
        wr(ADDR_IRQ, 16'h0000);
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_CONTROL, 16'h8040);
        idle(40);
        rd(ADDR_COUNT, v);
        check("gate low", v, 16'h0000);
        rd(ADDR_IRQ, v);
        check("no flag yet", v, 16'h0000);
        src_u.setGate(1'b1);
        idle(40);
        src_u.setGate(1'b0);
        idle(10);
        rd(ADDR_COUNT, v);
        chkRange("gate high", v, 16'h0011, 16'h0017);
        rd(ADDR_IRQ, v);
        check("gate fall flag", v, 16'h0001);
        results();
    end
endmodule : interval_timer_tb
